// ===== its_pkg.sv
package its_pkg;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] ADDR_SRC_SEL = 8'h00;
    localparam logic [7:0] ADDR_OP_CTRL = 8'h04;
    localparam logic [7:0] ADDR_SLOT_LO = 8'h08;
    localparam logic [7:0] ADDR_SLOT_HI = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [7:0] RST_FREQ_SRC = 8'h00;
    localparam logic [7:0] RST_RUN_SRC = 8'h02;
    localparam logic [1:0] RST_OP_CTRL = 2'h0;
    localparam logic [2:0] RST_IRQ_EN = 3'h0;

    // ***************************************************************
    // source and input function codes
    // ***************************************************************
    localparam logic [7:0] SRC_TERMINALS = 8'h01;
    localparam logic [7:0] FN_FORWARD = 8'h00;
    localparam logic [7:0] FN_REVERSE = 8'h01;
    localparam logic [7:0] FN_SPEED0 = 8'h02;
    localparam logic [7:0] FN_SPEED1 = 8'h03;
    localparam logic [7:0] FN_RESET = 8'h12;
    // option codes 51 and 52 decimal
    localparam logic [7:0] FN_FORCE_TERM = 8'h33;
    localparam logic [7:0] FN_READY = 8'h34;
    localparam logic [7:0] FN_EMERGENCY = 8'h40;
    localparam logic [7:0] FN_NONE = 8'hFF;

    // ***************************************************************
    // interrupt bit positions
    // ***************************************************************
    localparam int IRQ_FORCE_CHG = 0;
    localparam int IRQ_ESTOP = 1;
    localparam int IRQ_SWITCH_CHG = 2;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_MHZ = 50;
    localparam int START_DELAY_NS = 2000;
    localparam int STOP_DELAY_NS = 1000;
    localparam int START_CYCLES = (START_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int STOP_CYCLES = (STOP_DELAY_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [7:0] run_src;
        logic [7:0] freq_src;
    } its_src_t;

    typedef logic [4:0][7:0] its_slots_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_RUN = 4'b0100,
        ST_STOP = 4'b1000
    } its_state_t;

endpackage

// ===== its_core.sv
// Operation
// - while the force-terminal input is on, frequency and run sources both come from terminals.
// - with the force-terminal input off, the user's two source settings apply again.
// - a change of force-terminal input while driving first stops the motor, then applies.
// - force-terminal and ready functions can be placed in input slots three, four or five.
// - while ready is active the output stage stays energised so a run command acts at once.
// - with ready off a run command goes through the normal start sequence.
// - with safe-stop on, an opened emergency contact on input three cuts drive by hardware.
// - safe-stop on sets input three to emergency stop and input four to reset and locks both.
// - safe-stop on makes input five unassigned until software assigns it.
// - safe-stop on to off makes input three unassigned, keeps input four as reset, five unset.
// - inputs one and two stay forward and reverse; defaults are speed bits and reset on five.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module its_core
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [4:0] terminal_in,
    input wire logic safe_stop_switch,
    output its_pkg::its_src_t effective_src,
    output logic output_stage_on,
    output logic motor_run,
    output logic run_reverse,
    output logic [1:0] multispeed_sel,
    output logic irq
);

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic [4:0] term;
    logic safe_on;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta_reg <= 6'h00;
            pin_sync_reg <= 6'h00;
        end
        else
        begin
            pin_meta_reg <= {safe_stop_switch, terminal_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign term = pin_sync_reg[4:0];
    assign safe_on = pin_sync_reg[5];

    // ***************************************************************
    // registers
    // ***************************************************************
    its_pkg::its_src_t src_reg;
    logic [1:0] op_ctrl_reg;
    its_pkg::its_slots_t slot_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_en_reg;
    logic safe_prev_reg;
    logic applied_force_reg;
    logic force_prev_reg;
    logic estop_reg;
    its_pkg::its_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [31:0] hrdata_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;

    // true when any slot carrying this function sees its terminal high
    function automatic logic fn_on(input its_pkg::its_slots_t slots, input logic [4:0] lv,
                                   input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            if (slots[i] == code && lv[i])
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // ***************************************************************
    // bus slave
    // ***************************************************************
    logic addr_ok;
    logic wr_now;
    logic clr_now;
    logic slot_lo_wr;
    logic slot_hi_wr;

    assign addr_ok = hsel && hready && htrans[1];
    assign wr_now = wr_pend_reg;
    assign clr_now = wr_now && addr_reg == its_pkg::ADDR_IRQ_CLR;
    assign slot_lo_wr = wr_now && addr_reg == its_pkg::ADDR_SLOT_LO;
    assign slot_hi_wr = wr_now && addr_reg == its_pkg::ADDR_SLOT_HI;
    // one wait state on reads so the answer reflects a write just before it
    assign hreadyout = !rd_pend_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            if (addr_ok)
            begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_reg <= 32'h00000000;
        end
        else if (rd_pend_reg)
        begin
            unique case (addr_reg)
                its_pkg::ADDR_SRC_SEL: hrdata_reg <= {16'h0000, src_reg};
                its_pkg::ADDR_OP_CTRL: hrdata_reg <= {30'h00000000, op_ctrl_reg};
                its_pkg::ADDR_SLOT_LO: hrdata_reg <= {slot_reg[3], slot_reg[2],
                                                      slot_reg[1], slot_reg[0]};
                its_pkg::ADDR_SLOT_HI: hrdata_reg <= {24'h000000, slot_reg[4]};
                its_pkg::ADDR_STATUS: hrdata_reg <= {11'h000, term, 6'h00, state_reg,
                                                     output_stage_on, estop_reg, safe_on,
                                                     fn_on(slot_reg, term, its_pkg::FN_READY),
                                                     force_prev_reg, applied_force_reg};
                its_pkg::ADDR_IRQ_STAT: hrdata_reg <= {29'h00000000, irq_stat_reg};
                its_pkg::ADDR_IRQ_EN: hrdata_reg <= {29'h00000000, irq_en_reg};
                default: hrdata_reg <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_reg <= '{run_src: its_pkg::RST_RUN_SRC, freq_src: its_pkg::RST_FREQ_SRC};
            op_ctrl_reg <= its_pkg::RST_OP_CTRL;
            irq_en_reg <= its_pkg::RST_IRQ_EN;
        end
        else if (wr_now)
        begin
            if (addr_reg == its_pkg::ADDR_SRC_SEL)
            begin
                src_reg <= hwdata[15:0];
            end
            if (addr_reg == its_pkg::ADDR_OP_CTRL)
            begin
                op_ctrl_reg <= hwdata[1:0];
            end
            if (addr_reg == its_pkg::ADDR_IRQ_EN)
            begin
                irq_en_reg <= hwdata[2:0];
            end
        end
    end

    // ***************************************************************
    // input function slots
    // ***************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            slot_reg[0] <= its_pkg::FN_FORWARD;
            slot_reg[1] <= its_pkg::FN_REVERSE;
            slot_reg[2] <= its_pkg::FN_SPEED0;
            slot_reg[3] <= its_pkg::FN_SPEED1;
            slot_reg[4] <= its_pkg::FN_RESET;
            safe_prev_reg <= 1'b0;
        end
        else
        begin
            safe_prev_reg <= safe_on;
            if (safe_on && !safe_prev_reg)
            begin
                slot_reg[2] <= its_pkg::FN_EMERGENCY;
                slot_reg[3] <= its_pkg::FN_RESET;
                slot_reg[4] <= its_pkg::FN_NONE;
            end
            else if (!safe_on && safe_prev_reg)
            begin
                slot_reg[2] <= its_pkg::FN_NONE;
                slot_reg[4] <= its_pkg::FN_NONE;
            end
            else
            begin
                // slots one and two are fixed; three and four lock while safe-stop is on
                if (slot_lo_wr && !safe_on)
                begin
                    slot_reg[2] <= hwdata[23:16];
                    slot_reg[3] <= hwdata[31:24];
                end
                if (slot_hi_wr)
                begin
                    slot_reg[4] <= hwdata[7:0];
                end
            end
        end
    end

    // ***************************************************************
    // emergency path
    // ***************************************************************
    logic contact_open;
    logic hw_kill;
    logic rs_on;

    // normally-closed contact: a low level on input three means emergency
    assign contact_open = safe_on && !term[2];
    assign hw_kill = contact_open || estop_reg;
    assign rs_on = fn_on(slot_reg, term, its_pkg::FN_RESET);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            estop_reg <= 1'b0;
        end
        else if (contact_open)
        begin
            estop_reg <= 1'b1;
        end
        else if (rs_on)
        begin
            estop_reg <= 1'b0;
        end
    end

    // ***************************************************************
    // source selection and motor sequence
    // ***************************************************************
    logic force_in;
    logic ready_in;
    logic run_cmd;
    logic rev_cmd;
    logic run_term;

    assign force_in = fn_on(slot_reg, term, its_pkg::FN_FORCE_TERM);
    assign ready_in = fn_on(slot_reg, term, its_pkg::FN_READY);
    assign effective_src.freq_src = applied_force_reg ? its_pkg::SRC_TERMINALS
                                                      : src_reg.freq_src;
    assign effective_src.run_src = applied_force_reg ? its_pkg::SRC_TERMINALS
                                                     : src_reg.run_src;
    assign run_term = effective_src.run_src == its_pkg::SRC_TERMINALS;
    assign rev_cmd = run_term ? fn_on(slot_reg, term, its_pkg::FN_REVERSE) : op_ctrl_reg[1];
    assign run_cmd = run_term ? (fn_on(slot_reg, term, its_pkg::FN_FORWARD) || rev_cmd)
                              : op_ctrl_reg[0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= its_pkg::ST_IDLE;
            cnt_reg <= 8'h00;
            applied_force_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                its_pkg::ST_IDLE:
                begin
                    // new selection applies only while nothing is driven
                    applied_force_reg <= force_in;
                    if (run_cmd && !hw_kill && force_in == applied_force_reg)
                    begin
                        if (ready_in)
                        begin
                            state_reg <= its_pkg::ST_RUN;
                        end
                        else
                        begin
                            state_reg <= its_pkg::ST_START;
                            cnt_reg <= 8'(its_pkg::START_CYCLES - 1);
                        end
                    end
                end
                its_pkg::ST_START:
                begin
                    if (hw_kill)
                    begin
                        state_reg <= its_pkg::ST_IDLE;
                    end
                    else if (!run_cmd || force_in != applied_force_reg)
                    begin
                        state_reg <= its_pkg::ST_STOP;
                        cnt_reg <= 8'(its_pkg::STOP_CYCLES - 1);
                    end
                    else if (cnt_reg == 8'h00)
                    begin
                        state_reg <= its_pkg::ST_RUN;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                its_pkg::ST_RUN:
                begin
                    if (hw_kill)
                    begin
                        state_reg <= its_pkg::ST_IDLE;
                    end
                    else if (!run_cmd || force_in != applied_force_reg)
                    begin
                        state_reg <= its_pkg::ST_STOP;
                        cnt_reg <= 8'(its_pkg::STOP_CYCLES - 1);
                    end
                end
                its_pkg::ST_STOP:
                begin
                    if (hw_kill || cnt_reg == 8'h00)
                    begin
                        state_reg <= its_pkg::ST_IDLE;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default:
                begin
                    state_reg <= its_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    logic stage_core;

    // the kill term sits after the sequencer so no software state can hold drive on
    assign stage_core = state_reg != its_pkg::ST_IDLE || ready_in;
    assign output_stage_on = stage_core && !hw_kill;
    assign motor_run = state_reg == its_pkg::ST_RUN && !hw_kill;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_reverse <= 1'b0;
            multispeed_sel <= 2'h0;
        end
        else
        begin
            run_reverse <= rev_cmd;
            multispeed_sel <= {fn_on(slot_reg, term, its_pkg::FN_SPEED1),
                               fn_on(slot_reg, term, its_pkg::FN_SPEED0)};
        end
    end

    // ***************************************************************
    // interrupts
    // ***************************************************************
    logic [2:0] irq_set;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            force_prev_reg <= 1'b0;
        end
        else
        begin
            force_prev_reg <= force_in;
        end
    end

    assign irq_set = {safe_on != safe_prev_reg, contact_open && !estop_reg,
                      force_in != force_prev_reg};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_reg <= 3'h0;
        end
        else
        begin
            // a set in the clearing cycle wins
            irq_stat_reg <= (irq_stat_reg & ~(clr_now ? hwdata[2:0] : 3'h0)) | irq_set;
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

endmodule

// ===== its_core_asserts.sv
`timescale 1ns/1ps
module its_core_asserts
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [4:0] terminal_in,
    input wire logic safe_stop_switch,
    input wire its_pkg::its_src_t effective_src,
    input wire logic output_stage_on,
    input wire logic motor_run
);
    // ***************************************************************
    // properties
    // ***************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");

    property p_rd_wait;
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read without wait state");

    property p_wr_nowait;
        hsel && hready && htrans[1] && hwrite |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");

    property p_one_wait;
        !hreadyout |=> hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state too long");

    // five samples cover the two sync flops; the kill path reads input three directly, not the slots
    property p_estop;
        (safe_stop_switch && !terminal_in[2]) [*5] |-> !motor_run && !output_stage_on;
    endproperty
    a_estop: assert property (p_estop) else $error("drive kept on emergency");

    property p_stage_run;
        motor_run |-> output_stage_on;
    endproperty
    a_stage_run: assert property (p_stage_run) else $error("running with stage off");

    property p_src_stable;
        motor_run |=> $stable(effective_src);
    endproperty
    a_src_stable: assert property (p_src_stable) else $error("source changed running");

    property p_stop_hold;
        $fell(motor_run) |=> !motor_run [*8];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("restart inside stop");
endmodule

bind its_core its_core_asserts i_its_core_asserts
(
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .terminal_in(terminal_in),
    .safe_stop_switch(safe_stop_switch),
    .effective_src(effective_src),
    .output_stage_on(output_stage_on),
    .motor_run(motor_run)
);

// ===== its_term_model.sv
`timescale 1ns/1ps
module its_term_model
(
    input wire logic hclk,
    input wire logic [4:0] want_terms,
    input wire logic want_switch,
    output logic [4:0] terminal_in,
    output logic safe_stop_switch
);
    // ***************************************************************
    // contacts and switch
    // ***************************************************************
    // pins move one edge after the command, unrelated to the bus
    // input three high means the emergency contact is closed
    always_ff @(posedge hclk)
    begin
        terminal_in <= want_terms;
        safe_stop_switch <= want_switch;
    end
endmodule

// ===== its_core_tb.sv
`timescale 1ns/1ps
module its_core_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, want_switch;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, multispeed_sel;
    logic [2:0] hsize;
    logic [4:0] terminal_in, want_terms;
    logic safe_stop_switch, output_stage_on, motor_run, run_reverse;
    its_pkg::its_src_t effective_src;
    int miscompares, cmp_count, n, k;

    // ***************************************************************
    // design and contacts
    // ***************************************************************
    assign hready = hreadyout;
    its_core i_its_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .terminal_in(terminal_in),
        .safe_stop_switch(safe_stop_switch), .effective_src(effective_src),
        .output_stage_on(output_stage_on), .motor_run(motor_run),
        .run_reverse(run_reverse), .multispeed_sel(multispeed_sel), .irq(irq));
    its_term_model i_its_term_model (.hclk(hclk), .want_terms(want_terms),
        .want_switch(want_switch), .terminal_in(terminal_in),
        .safe_stop_switch(safe_stop_switch));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ***************************************************************
    // tasks
    // ***************************************************************
    task close_out;
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task check(input string s, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task wait_ready;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            miscompares++;
            close_out();
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
        ahb(1'b0, a, 32'h0);
        check(s, rd, e);
    endtask

    task cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask

    task pins(input logic [4:0] t, input logic s, input int c);
        want_terms <= t;
        want_switch <= s;
        cyc(c);
    endtask

    // bounded wait for the motor to reach a level, n counts the edges
    task run_wait(input logic v, input int lim);
        n = 0;
        while (motor_run !== v && n < lim)
        begin
            @(posedge hclk);
            n++;
        end
        check("motor_run", {31'h0, motor_run}, {31'h0, v});
        if (motor_run !== v)
        begin
            close_out();
        end
    endtask

    // ***************************************************************
    // sequence
    // ***************************************************************
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        want_terms = 5'h00;
        want_switch = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        cyc(16);
        hresetn <= 1'b1;
        cyc(1);
        rdchk(its_pkg::ADDR_SRC_SEL, 32'h0000_0200, "src_sel");
        check("eff", {16'h0, effective_src}, 32'h0200);
        rdchk(its_pkg::ADDR_SLOT_LO, 32'h0302_0100, "slot_lo");
        rdchk(its_pkg::ADDR_SLOT_HI, 32'h0000_0012, "slot_hi");
        rdchk(8'h20, 32'h0, "unmapped");
        pins(5'h04, 1'b0, 8);
        check("speed", {30'h0, multispeed_sel}, 32'h1);
        ahb(1'b1, its_pkg::ADDR_SLOT_HI, {24'h0, its_pkg::FN_FORCE_TERM});
        ahb(1'b1, its_pkg::ADDR_SRC_SEL, 32'h0000_0302);
        pins(5'h10, 1'b0, 8);
        check("eff", {16'h0, effective_src}, 32'h0101);
        check("irq_masked", {31'h0, irq}, 32'h0);
        ahb(1'b1, its_pkg::ADDR_IRQ_EN, 32'h7);
        cyc(1);
        check("irq_on", {31'h0, irq}, 32'h1);
        ahb(1'b1, its_pkg::ADDR_IRQ_CLR, 32'h7);
        cyc(1);
        check("irq_off", {31'h0, irq}, 32'h0);
        pins(5'h00, 1'b0, 8);
        check("eff", {16'h0, effective_src}, 32'h0302);
        ahb(1'b1, its_pkg::ADDR_SLOT_LO, 32'h3402_0100);
        pins(5'h08, 1'b0, 8);
        check("stage_ready", {31'h0, output_stage_on}, 32'h1);
        ahb(1'b1, its_pkg::ADDR_OP_CTRL, 32'h3);
        run_wait(1'b1, 20);
        check("ready_fast", {31'h0, n < 4}, 32'h1);
        check("reverse", {31'h0, run_reverse}, 32'h1);
        ahb(1'b1, its_pkg::ADDR_OP_CTRL, 32'h0);
        run_wait(1'b0, 20);
        pins(5'h00, 1'b0, 60);
        check("stage_idle", {31'h0, output_stage_on}, 32'h0);
        ahb(1'b1, its_pkg::ADDR_OP_CTRL, 32'h1);
        run_wait(1'b1, 200);
        check("start_len", {31'h0, n >= 95 && n <= 105}, 32'h1);
        pins(5'h10, 1'b0, 0);
        run_wait(1'b0, 20);
        check("eff_hold", {16'h0, effective_src}, 32'h0302);
        cyc(60);
        check("eff_late", {16'h0, effective_src}, 32'h0101);
        ahb(1'b1, its_pkg::ADDR_OP_CTRL, 32'h0);
        pins(5'h00, 1'b0, 60);
        pins(5'h04, 1'b1, 8);
        rdchk(its_pkg::ADDR_SLOT_LO, 32'h1240_0100, "slot_lo_safe");
        rdchk(its_pkg::ADDR_SLOT_HI, 32'h0000_00FF, "slot_hi_safe");
        ahb(1'b1, its_pkg::ADDR_SLOT_LO, 32'h0303_0303);
        rdchk(its_pkg::ADDR_SLOT_LO, 32'h1240_0100, "slot_lock");
        ahb(1'b1, its_pkg::ADDR_SLOT_HI, 32'h0000_0002);
        rdchk(its_pkg::ADDR_SLOT_HI, 32'h0000_0002, "slot5_manual");
        ahb(1'b1, its_pkg::ADDR_OP_CTRL, 32'h1);
        run_wait(1'b1, 200);
        pins(5'h00, 1'b1, 4);
        check("estop_run", {31'h0, motor_run}, 32'h0);
        check("estop_stage", {31'h0, output_stage_on}, 32'h0);
        ahb(1'b0, its_pkg::ADDR_IRQ_STAT, 32'h0);
        check("estop_irq", {31'h0, rd[1]}, 32'h1);
        pins(5'h04, 1'b1, 20);
        check("latched", {31'h0, motor_run}, 32'h0);
        rdchk(its_pkg::ADDR_STATUS, 32'h0004_0058, "status_latched");
        pins(5'h0C, 1'b1, 8);
        pins(5'h04, 1'b1, 0);
        run_wait(1'b1, 200);
        ahb(1'b1, its_pkg::ADDR_OP_CTRL, 32'h0);
        run_wait(1'b0, 20);
        pins(5'h00, 1'b0, 60);
        rdchk(its_pkg::ADDR_SLOT_LO, 32'h12FF_0100, "slot_lo_off");
        rdchk(its_pkg::ADDR_SLOT_HI, 32'h0000_00FF, "slot_hi_off");
        close_out();
    end
endmodule
